// ---- scr_config_bank.sv ----
// Top of the synthesizer configuration bank with APB slave and field outputs
// Contract
// - code 001 writes fine fraction/phase word
// - code 010 writes reference path word
// - code 011 writes function word
// - fine bit 28 phase enable, 14:3 phase
// - fraction equals low plus high times 8192
// - phase step applies after integer write
// - reference bit 28 enables slip reduction
// - reference bits 27:24 pump current
// - bit 21 inserts divide-by-two stage
// - bit 20 selects reference doubling
// - bits 19:15 reference divide 1 to 32
// - bits 14:3 ramp step divider
// - function bit 21 bleed, 24:22 magnitude
// - function bit 16 lock loss indication
// - bit 15 aligns integer with fraction load
// - bit 14 zero resets modulator per integer write
// - function bits 11:10 ramp waveform
// - function bit 9 phase keying
// - function bit 8 frequency keying
// - code 000 writes integer word
`timescale 1ns/1ps
`include "scr_map.svh"

module scr_config_bank (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pfd_tick,
  output logic [24:0] fine_divide_word,
  output logic [11:0] phase_step_word,
  output logic phase_step_pulse,
  output logic slip_reduction_enable,
  output logic [3:0] pump_current,
  output logic prescaler_high,
  output logic ref_half_divide,
  output logic ref_double,
  output logic [5:0] ref_divide_ratio,
  output logic [11:0] ramp_step_divider,
  output logic bleed_enable,
  output logic [2:0] bleed_level,
  output logic lock_loss_indicate,
  output logic lock_loss_unreliable,
  output logic int_load_pulse,
  output logic fine_divide_word_load_pulse,
  output logic mod_reset_pulse,
  output logic [1:0] ramp_waveform,
  output logic psk_enable,
  output logic fsk_enable
);

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic setup;           // Setup phase of any transfer
  logic access;          // Access phase; writes answered in its first cycle, reads in its second
  logic wr_hit;          // Write to the serial word port
  logic [2:0] wr_code;   // Control code carried in the word
  logic rd_busy_reg;     // Second cycle of a read access
  scr_pkg::scr_word_t bank_rd;  // Registered read of the bank
  logic [2:0] rd_idx;    // Read index into the bank
  logic [7:0] rd_addr_reg;      // Address captured for read mux

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_code = pwdata[`SCR_CODE_HI:`SCR_CODE_LO];
  // Words land by their own code, not by address; the address only
  // has to point at the word port (any of the first four slots).
  assign wr_hit = access && pwrite && (paddr < `SCR_ADDR_STATUS) && pready;
  assign rd_idx = paddr[4:2];

  // Reads take two access cycles so the bank's registered port settles
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_busy_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
    end else begin
      rd_busy_reg <= access && !pwrite && !rd_busy_reg;
      if (setup) begin
        rd_addr_reg <= paddr;
      end
    end
  end

  // Ready: writes answer in the first access cycle, reads in the second
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= (setup && pwrite) || (access && !pwrite && !rd_busy_reg);
      // Error stands with ready, so a refused read reports it as well
      pslverr <= ((setup && pwrite) || (access && !pwrite && !rd_busy_reg)) &&
                 (paddr > `SCR_ADDR_SHADOW || paddr[1:0] != 2'h0);
    end
  end

  // ------------------------------------------------------------
  // Word storage
  // ------------------------------------------------------------
  scr_word_bank u_bank (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(wr_hit && !wr_code[2]),
    .wr_idx(wr_code),
    .wr_word(pwdata),
    .rd_idx(rd_idx),
    .rd_word(bank_rd)
  );

  // Local copies that drive field outputs; each updates whole
  scr_pkg::scr_word_t int_reg;
  scr_pkg::scr_word_t fine_reg;
  scr_pkg::scr_word_t ref_reg;
  scr_pkg::scr_word_t func_reg;
  logic int_write;  // One-cycle strobe of an integer word write

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      int_reg <= `SCR_WORD_RST;
      fine_reg <= `SCR_WORD_RST;
      ref_reg <= `SCR_WORD_RST;
      func_reg <= `SCR_FN_RST;
      int_write <= 1'b0;
    end else begin
      int_write <= wr_hit && wr_code == `SCR_IDX_INT;
      if (wr_hit) begin
        unique case (wr_code)
          `SCR_IDX_INT: int_reg <= pwdata;
          `SCR_IDX_FINE: fine_reg <= pwdata;
          `SCR_IDX_REF: ref_reg <= pwdata;
          `SCR_IDX_FUNC: func_reg <= pwdata;
          default: ;                          // Codes 4 to 7 are dropped, no slot takes them
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Load sequencing
  // ------------------------------------------------------------
  logic int_load;
  logic fine_divide_word_load;
  logic mod_reset;

  scr_load_seq u_seq (
    .mclk(mclk),
    .nrst(nrst),
    .pfd_tick(pfd_tick),
    .int_write(int_write),
    .align_en(func_reg[`SCR_FN_NSEL_BIT]),
    .hold_mod(func_reg[`SCR_FN_SDRST_BIT]),
    .int_load(int_load),
    .fine_divide_word_load(fine_divide_word_load),
    .mod_reset(mod_reset)
  );

  // ------------------------------------------------------------
  // Fine word and phase outputs
  // ------------------------------------------------------------
  // Fraction is refreshed only on the fraction load so the divider
  // never sees a half-updated word.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fine_divide_word <= 25'h0000000;
      phase_step_word <= 12'h000;
      phase_step_pulse <= 1'b0;
    end else begin
      if (fine_divide_word_load) begin
        fine_divide_word <= {int_reg[`SCR_INT_FRACMSB_HI:`SCR_INT_FRACMSB_LO],
                             fine_reg[`SCR_FINE_FRACLSB_HI:`SCR_FINE_FRACLSB_LO]};
      end
      // Phase moves by word*360/4096 degrees, only on integer writes
      phase_step_pulse <= int_write && fine_reg[`SCR_FINE_PHEN_BIT];
      if (int_write) begin
        phase_step_word <= fine_reg[`SCR_FINE_PHASE_HI:`SCR_FINE_PHASE_LO];
      end
    end
  end

  // ------------------------------------------------------------
  // Reference path outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slip_reduction_enable <= 1'b0;
      pump_current <= 4'h0;
      prescaler_high <= 1'b0;
      ref_half_divide <= 1'b0;
      ref_double <= 1'b0;
      ref_divide_ratio <= 6'h20;
      ramp_step_divider <= 12'h000;
    end else begin
      // Slip reduction is passed through; safe use is the host's job
      slip_reduction_enable <= ref_reg[`SCR_REF_SLIP_BIT];
      pump_current <= ref_reg[`SCR_REF_CP_HI:`SCR_REF_CP_LO];
      prescaler_high <= ref_reg[`SCR_REF_PRESC_BIT];
      ref_half_divide <= ref_reg[`SCR_REF_HALF_BIT];
      ref_double <= ref_reg[`SCR_REF_DBL_BIT];
      // Code 0 stands for 32 so ratios 1..32 all fit in five bits
      ref_divide_ratio <= (ref_reg[`SCR_REF_RCNT_HI:`SCR_REF_RCNT_LO] == 5'h00) ? 6'h20 :
                          {1'b0, ref_reg[`SCR_REF_RCNT_HI:`SCR_REF_RCNT_LO]};
      ramp_step_divider <= ref_reg[`SCR_REF_STEP_HI:`SCR_REF_STEP_LO];
    end
  end

  // ------------------------------------------------------------
  // Function outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bleed_enable <= 1'b0;
      bleed_level <= 3'h0;
      lock_loss_indicate <= 1'b0;
      lock_loss_unreliable <= 1'b0;
      ramp_waveform <= 2'h0;
      psk_enable <= 1'b0;
      fsk_enable <= 1'b0;
    end else begin
      bleed_enable <= func_reg[`SCR_FN_BLEEDEN_BIT];
      bleed_level <= func_reg[`SCR_FN_BLEED_HI:`SCR_FN_BLEED_LO];
      // Zero means flag even with the reference gone
      lock_loss_indicate <= !func_reg[`SCR_FN_LOCK_BIT];
      // Bleed current upsets the lock-loss detector
      lock_loss_unreliable <= func_reg[`SCR_FN_BLEEDEN_BIT];
      ramp_waveform <= func_reg[`SCR_FN_RAMP_HI:`SCR_FN_RAMP_LO];
      psk_enable <= func_reg[`SCR_FN_PSK_BIT];
      fsk_enable <= func_reg[`SCR_FN_FSK_BIT];
    end
  end

  // Load strobes straight from the sequencer flops, one cycle later
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      int_load_pulse <= 1'b0;
      fine_divide_word_load_pulse <= 1'b0;
      mod_reset_pulse <= 1'b0;
    end else begin
      int_load_pulse <= int_load;
      fine_divide_word_load_pulse <= fine_divide_word_load;
      mod_reset_pulse <= mod_reset;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Status slot shows the reserved-bit sanity of the function word
  // and the live divide word; the word slots are a debug shadow.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata <= `SCR_RDATA_ZERO;
    end else if (access && !pwrite && !rd_busy_reg) begin
      // Loaded with ready, so the data stand at the edge that takes them
      if (rd_addr_reg == `SCR_ADDR_STATUS) begin
        prdata <= {6'h00, func_reg[17], fine_divide_word};
      end else if (rd_addr_reg == `SCR_ADDR_SHADOW) begin
        prdata <= {29'h0, ref_divide_ratio[5], ref_half_divide, ref_double};
      end else if (rd_addr_reg < `SCR_ADDR_STATUS) begin
        prdata <= bank_rd;
      end else begin
        prdata <= `SCR_RDATA_ZERO;
      end
    end
  end

endmodule : scr_config_bank

// ---- scr_map.svh ----
// Register map, field positions and timing constants for the synthesizer config bank
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// ------------------------------------------------------------
// APB byte addresses (index times four)
// ------------------------------------------------------------
`define SCR_IDX_INT       3'h0
`define SCR_IDX_FINE      3'h1
`define SCR_IDX_REF       3'h2
`define SCR_IDX_FUNC      3'h3
`define SCR_ADDR_INT      8'h00
`define SCR_ADDR_FINE     8'h04
`define SCR_ADDR_REF      8'h08
`define SCR_ADDR_FUNC     8'h0C
`define SCR_ADDR_STATUS   8'h10
`define SCR_ADDR_SHADOW   8'h14

// ------------------------------------------------------------
// Control code field
// ------------------------------------------------------------
`define SCR_CODE_HI       2
`define SCR_CODE_LO       0

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define SCR_INT_FRACMSB_HI   14
`define SCR_INT_FRACMSB_LO   3
`define SCR_FINE_PHEN_BIT    28
`define SCR_FINE_FRACLSB_HI  27
`define SCR_FINE_FRACLSB_LO  15
`define SCR_FINE_PHASE_HI    14
`define SCR_FINE_PHASE_LO    3
`define SCR_REF_SLIP_BIT     28
`define SCR_REF_CP_HI        27
`define SCR_REF_CP_LO        24
`define SCR_REF_PRESC_BIT    22
`define SCR_REF_HALF_BIT     21
`define SCR_REF_DBL_BIT      20
`define SCR_REF_RCNT_HI      19
`define SCR_REF_RCNT_LO      15
`define SCR_REF_STEP_HI      14
`define SCR_REF_STEP_LO      3
`define SCR_FN_BLEED_HI      24
`define SCR_FN_BLEED_LO      22
`define SCR_FN_BLEEDEN_BIT   21
`define SCR_FN_LOCK_BIT      16
`define SCR_FN_NSEL_BIT      15
`define SCR_FN_SDRST_BIT     14
`define SCR_FN_RAMP_HI       11
`define SCR_FN_RAMP_LO       10
`define SCR_FN_PSK_BIT       9
`define SCR_FN_FSK_BIT       8

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define SCR_WORD_RST      32'h0000_0000
`define SCR_FN_RST        32'h0002_0003
`define SCR_NSEL_DELAY    3'h4
`define SCR_RDATA_ZERO    32'h0000_0000

`endif

// ---- scr_pkg.sv ----
// Types shared by the synthesizer config bank
package scr_pkg;
  // Delayed-load sequencer states
  typedef enum logic [1:0] {
    SCR_IDLE,
    SCR_WAIT,
    SCR_LOAD
  } scr_load_e;
  typedef logic [31:0] scr_word_t;
endpackage : scr_pkg

// ---- scr_word_bank.sv ----
// Small memory of the four coded configuration words
`timescale 1ns/1ps
`include "scr_map.svh"

module scr_word_bank (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire scr_pkg::scr_word_t wr_word,
  input wire logic [2:0] rd_idx,
  output scr_pkg::scr_word_t rd_word
);
  // ------------------------------------------------------------
  // Storage, one entry per code 0..3
  // ------------------------------------------------------------
  scr_pkg::scr_word_t mem_reg [0:3];

  // Each entry loads a whole word at once, others keep value
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ent
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          mem_reg[gi] <= (gi == 3) ? `SCR_FN_RST : `SCR_WORD_RST;
        end else if (wr_en && wr_idx == 3'(gi)) begin
          mem_reg[gi] <= wr_word;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_word <= `SCR_WORD_RST;
    end else if (rd_idx[2]) begin
      rd_word <= `SCR_WORD_RST;
    end else begin
      rd_word <= mem_reg[rd_idx[1:0]];
    end
  end
endmodule : scr_word_bank

// ---- scr_load_seq.sv ----
// Sequencer for integer/fraction load alignment and modulator reset
`timescale 1ns/1ps
`include "scr_map.svh"

module scr_load_seq (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pfd_tick,
  input wire logic int_write,
  input wire logic align_en,
  input wire logic hold_mod,
  output logic int_load,
  output logic fine_divide_word_load,
  output logic mod_reset
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  scr_pkg::scr_load_e state_reg;
  logic [2:0] cnt_reg;

  // Fraction loads four detector ticks after an integer write;
  // integer loads at once unless alignment asks it to wait.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= scr_pkg::SCR_IDLE;
      cnt_reg <= 3'h0;
      int_load <= 1'b0;
      fine_divide_word_load <= 1'b0;
      mod_reset <= 1'b0;
    end else begin
      int_load <= 1'b0;
      fine_divide_word_load <= 1'b0;
      mod_reset <= int_write && !hold_mod;
      unique case (state_reg)
        scr_pkg::SCR_IDLE: begin
          if (int_write) begin
            int_load <= !align_en;
            cnt_reg <= 3'h0;
            state_reg <= scr_pkg::SCR_WAIT;
          end
        end
        scr_pkg::SCR_WAIT: begin
          // A fresh write restarts the wait so both halves stay paired
          if (int_write) begin
            cnt_reg <= 3'h0;
            int_load <= !align_en;
          end else if (pfd_tick) begin
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg + 3'h1 == `SCR_NSEL_DELAY) begin
              state_reg <= scr_pkg::SCR_LOAD;
            end
          end
        end
        scr_pkg::SCR_LOAD: begin
          fine_divide_word_load <= 1'b1;
          int_load <= align_en;
          state_reg <= scr_pkg::SCR_IDLE;
        end
      endcase
    end
  end
endmodule : scr_load_seq

// ---- scr_bank_props.sv ----
// Port-level checks for the synthesizer config bank
`timescale 1ns/1ps

module scr_bank_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic slip_reduction_enable,
  input wire logic [3:0] pump_current,
  input wire logic prescaler_high,
  input wire logic ref_half_divide,
  input wire logic ref_double,
  input wire logic [5:0] ref_divide_ratio,
  input wire logic [11:0] ramp_step_divider,
  input wire logic bleed_enable,
  input wire logic [2:0] bleed_level,
  input wire logic lock_loss_indicate,
  input wire logic lock_loss_unreliable,
  input wire logic int_load_pulse,
  input wire logic fine_divide_word_load_pulse,
  input wire logic mod_reset_pulse,
  input wire logic [1:0] ramp_waveform,
  input wire logic psk_enable,
  input wire logic fsk_enable
);
  // ----------------------------------------
  // Helper copies of the stored words
  // ----------------------------------------
  logic wr; // Accepted write to a word slot
  logic [31:0] ref_reg, ref_d; // Reference word and its one-cycle copy
  logic [31:0] fn_reg, fn_d; // Function word and its one-cycle copy
  assign wr = psel && penable && pwrite && pready && (paddr < 8'h10);
  // Reference word shadow
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ref_reg <= 32'h0;
      ref_d <= 32'h0;
    end else begin
      if (wr && pwdata[2:0] == 3'h2) ref_reg <= pwdata;
      ref_d <= ref_reg;
    end
  end
  // Function word shadow, reset value keeps the mandatory bit set
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fn_reg <= 32'h0002_0003;
      fn_d <= 32'h0002_0003;
    end else begin
      if (wr && pwdata[2:0] == 3'h3) fn_reg <= pwdata;
      fn_d <= fn_reg;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_ref_fields: assert property (wr && pwdata[2:0] == 3'h2 |-> ##2
    {slip_reduction_enable, pump_current, prescaler_high, ref_half_divide, ref_double, ramp_step_divider}
    == {ref_d[28:24], ref_d[22:20], ref_d[14:3]}) else $error("reference fields wrong");
  a_rdiv_ratio: assert property (wr && pwdata[2:0] == 3'h2 |-> ##2
    ref_divide_ratio == ((ref_d[19:15] == 5'h00) ? 6'h20 : {1'b0, ref_d[19:15]})) else $error("ratio wrong");
  a_bleed_fields: assert property (wr && pwdata[2:0] == 3'h3 |-> ##2
    {bleed_enable, bleed_level} == {fn_d[21], fn_d[24:22]}) else $error("bleed fields wrong");
  a_lock_field: assert property (wr && pwdata[2:0] == 3'h3 |-> ##2
    lock_loss_indicate == !fn_d[16]) else $error("lock loss field wrong");
  a_unrel_tracks: assert property (lock_loss_unreliable == bleed_enable)
    else $error("unreliable flag wrong");
  a_ramp_keying: assert property (wr && pwdata[2:0] == 3'h3 |-> ##2
    {ramp_waveform, psk_enable, fsk_enable} == fn_d[11:8]) else $error("ramp or keying wrong");
  a_align_load: assert property (int_load_pulse && fn_reg[15] |-> fine_divide_word_load_pulse)
    else $error("integer load not aligned");
  a_mod_reset_gate: assert property (mod_reset_pulse |-> !fn_reg[14])
    else $error("modulator reset while held");
  a_write_ready: assert property (psel && !penable && pwrite |=> pready)
    else $error("write not answered at once");
  a_read_wait: assert property (psel && !penable && !pwrite && paddr < 8'h10 |=> !pready ##1 pready)
    else $error("read wait wrong");
  a_bad_addr_err: assert property (psel && !penable && pwrite && paddr > 8'h14 |=> pslverr && pready)
    else $error("bad address not refused");
  c_aligned: cover property (int_load_pulse && fine_divide_word_load_pulse);
  c_mod_reset: cover property (mod_reset_pulse);
  c_refused: cover property (pslverr);
endmodule : scr_bank_props

bind scr_config_bank scr_bank_props u_props (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .slip_reduction_enable, .pump_current, .prescaler_high, .ref_half_divide, .ref_double,
  .ref_divide_ratio, .ramp_step_divider, .bleed_enable, .bleed_level, .lock_loss_indicate, .lock_loss_unreliable,
  .int_load_pulse, .fine_divide_word_load_pulse, .mod_reset_pulse, .ramp_waveform, .psk_enable, .fsk_enable);

// ---- scr_pfd_model.sv ----
// Detector tick source standing in for the analog reference path
`timescale 1ns/1ps

module scr_pfd_model #(
  parameter int TICK_GAP = 3 // Cycles between ticks, small to keep runs short
) (
  input wire logic mclk,
  input wire logic nrst,
  output logic pfd_tick
);
  logic [7:0] cnt_reg; // Cycles since last tick
  // One-cycle tick every TICK_GAP cycles
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 8'h00;
      pfd_tick <= 1'b0;
    end else begin
      pfd_tick <= (cnt_reg == 8'(TICK_GAP - 1));
      cnt_reg <= (cnt_reg == 8'(TICK_GAP - 1)) ? 8'h00 : cnt_reg + 8'h01;
    end
  end
endmodule : scr_pfd_model

// ---- test_synth_config_regs_r1_r3.sv ----
// Self-checking bench for the synthesizer config bank
`timescale 1ns/1ps
`include "scr_map.svh"

module test_synth_config_regs_r1_r3;
  // ----------------------------------------
  // Signals and bench state
  // ----------------------------------------
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr, pfd_tick;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [24:0] fine_divide_word;
  logic [11:0] phase_step_word, ramp_step_divider;
  logic phase_step_pulse, slip_reduction_enable, prescaler_high, ref_half_divide, ref_double;
  logic [3:0] pump_current;
  logic [5:0] ref_divide_ratio;
  logic bleed_enable, lock_loss_indicate, lock_loss_unreliable, int_load_pulse, fine_divide_word_load_pulse;
  logic mod_reset_pulse, psk_enable, fsk_enable;
  logic [2:0] bleed_level;
  logic [1:0] ramp_waveform;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  logic [31:0] seed = 32'h56E348EC;
  logic [31:0] fw, rw, fnw; // Words last written to the fine, reference and function slots

  scr_config_bank dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pfd_tick, .fine_divide_word, .phase_step_word, .phase_step_pulse, .slip_reduction_enable, .pump_current,
    .prescaler_high, .ref_half_divide, .ref_double, .ref_divide_ratio, .ramp_step_divider, .bleed_enable,
    .bleed_level, .lock_loss_indicate, .lock_loss_unreliable, .int_load_pulse, .fine_divide_word_load_pulse,
    .mod_reset_pulse, .ramp_waveform, .psk_enable, .fsk_enable);
  scr_pfd_model #(.TICK_GAP(3)) u_pfd (.mclk, .nrst, .pfd_tick);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task stop_test;
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: value mismatch", $time);
    end
  endtask : chk

  // One APB transfer; an idle cycle first so strobes never change twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic experr);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("unexpected at %0t: no ready", $time);
      stop_test();
    end
    chk(pslverr === experr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0, 1'b0);
  endtask : rd

  // Field outputs against the words last written
  task chk_fields;
    chk(slip_reduction_enable === rw[28]);
    chk(pump_current === rw[27:24]);
    chk(prescaler_high === rw[22]);
    chk(ref_half_divide === rw[21]);
    chk(ref_double === rw[20]);
    chk(ref_divide_ratio === ((rw[19:15] == 5'h00) ? 6'h20 : {1'b0, rw[19:15]}));
    chk(ramp_step_divider === rw[14:3]);
    chk({bleed_enable, bleed_level} === {fnw[21], fnw[24:22]});
    chk({lock_loss_indicate, lock_loss_unreliable} === {!fnw[16], fnw[21]});
    chk({ramp_waveform, psk_enable, fsk_enable} === fnw[11:8]);
  endtask : chk_fields

  // Integer write, then count the load, reset and phase pulses that follow
  task int_run(input logic [31:0] iw, input logic align, input logic hold, input logic ph);
    int n, mr, il, fl, co, ps;
    mr = 0;
    il = 0;
    fl = 0;
    co = 0;
    ps = 0;
    apb(1'b1, 8'h00, iw, 1'b0);
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      mr += int'(mod_reset_pulse === 1'b1);
      il += int'(int_load_pulse === 1'b1);
      fl += int'(fine_divide_word_load_pulse === 1'b1);
      co += int'(int_load_pulse === 1'b1 && fine_divide_word_load_pulse === 1'b1);
      ps += int'(phase_step_pulse === 1'b1);
    end
    chk(mr == (hold ? 0 : 1));
    chk(il == 1 && fl == 1 && co == (align ? 1 : 0));
    chk(ps == (ph ? 1 : 0));
    chk(phase_step_word === fw[14:3]);
    chk(fine_divide_word === {iw[14:3], fw[27:15]});
    rd(`SCR_ADDR_STATUS, {6'h00, fnw[17], iw[14:3], fw[27:15]});
    rd(`SCR_ADDR_SHADOW, {29'h0, rw[19:15] == 5'h00, rw[21], rw[20]});
  endtask : int_run

  // ----------------------------------------
  // Clock, read monitor and main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Each completed read takes the oldest expectation
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      num_checks++;
      if (exp_q.size() == 0 || prdata !== exp_q.pop_front()) begin
        err_count++;
        $display("unexpected at %0t: read data", $time);
      end
    end
  end

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk(ref_divide_ratio === 6'h20 && pump_current === 4'h0 && fine_divide_word === 25'h0);
    rd(`SCR_ADDR_FUNC, `SCR_FN_RST);
    // Random legal words; boundary divide fields on the first two passes
    for (int i = 0; i < 6; i++) begin
      fw = (xs() & 32'h1FFF_FFF8) | 32'h1;
      rw = (xs() & 32'h1F7F_FFF8) | 32'h2;
      if (i < 2) rw[19:15] = (i == 0) ? 5'h00 : 5'h1F;
      if (rw[28]) rw[27:24] = 4'h0;
      fnw = (xs() & 32'h01E1_CF00) | 32'h0002_0043;
      apb(1'b1, `SCR_ADDR_FINE, fw, 1'b0);
      apb(1'b1, `SCR_ADDR_REF, rw, 1'b0);
      apb(1'b1, `SCR_ADDR_FUNC, fnw, 1'b0);
      repeat (3) @(posedge mclk);
      chk_fields();
      rd(`SCR_ADDR_FINE, fw);
      rd(`SCR_ADDR_REF, rw);
      rd(`SCR_ADDR_FUNC, fnw);
    end
    // Codes 4 to 7 must leave every slot alone
    for (int i = 4; i < 8; i++) begin
      apb(1'b1, `SCR_ADDR_REF, (xs() & 32'hFFFF_FFF8) | 32'(i), 1'b0);
    end
    rd(`SCR_ADDR_REF, rw);
    rd(`SCR_ADDR_INT, 32'h0);
    // The code, not the address, picks the slot
    fw = (xs() & 32'h0FFF_FFF8) | 32'h1000_0001;
    apb(1'b1, `SCR_ADDR_INT, fw, 1'b0);
    rd(`SCR_ADDR_FINE, fw);
    apb(1'b1, 8'h18, 32'h3, 1'b1);
    // A refused read answers zero with the error flag
    exp_q.push_back(`SCR_RDATA_ZERO);
    apb(1'b0, 8'h1C, 32'h0, 1'b1);
    fnw = 32'h0002_0043;
    apb(1'b1, `SCR_ADDR_FUNC, fnw, 1'b0);
    int_run((xs() & 32'h0000_7FF8) | 32'h0025_8000, 1'b0, 1'b0, 1'b1);
    fnw = 32'h0002_C043;
    fw = (xs() & 32'h0FFF_FFF8) | 32'h1;
    apb(1'b1, `SCR_ADDR_FUNC, fnw, 1'b0);
    apb(1'b1, `SCR_ADDR_FINE, fw, 1'b0);
    int_run((xs() & 32'h0000_7FF8) | 32'h0025_8000, 1'b1, 1'b1, 1'b0);
    stop_test();
  end
endmodule : test_synth_config_regs_r1_r3
